//--- design/cmb_pkg.sv
package cmb_pkg;
   // device register map
   localparam logic [7:0] A_CAN_CONTROL = 8'h00;
   localparam logic [7:0] A_CAN_CONFIG = 8'h01;
   localparam logic [7:0] A_TX_ERR = 8'h02;
   localparam logic [7:0] A_RX0_CON = 8'h10;
   localparam logic [7:0] A_RX0_SIDH = 8'h11;
   localparam logic [7:0] A_RX0_SIDL = 8'h12;
   localparam logic [7:0] A_RX0_LEN = 8'h15;
   localparam logic [7:0] A_RX0_D0 = 8'h16;
   localparam logic [7:0] A_RX0_LAST = 8'h1D;
   localparam logic [7:0] A_TX0_CON = 8'h20;
   localparam logic [7:0] A_TX0_SIDH = 8'h21;
   localparam logic [7:0] A_TX0_SIDL = 8'h22;
   localparam logic [7:0] A_TX0_EIDH = 8'h23;
   localparam logic [7:0] A_TX0_EIDL = 8'h24;
   localparam logic [7:0] A_TX0_LEN = 8'h25;
   localparam logic [7:0] A_TX0_D0 = 8'h26;
   localparam logic [7:0] A_WIN_SHIFT = 8'h10;
   // fields
   localparam logic [3:0] WIN_TX0 = 4'h8;
   localparam logic [7:0] WIN_KEEP_MASK = 8'hF0;
   localparam logic [7:0] TX_REQ_WORD = 8'h08;
   localparam logic [2:0] OPM_NORMAL = 3'h0;
   localparam logic [2:0] OPM_LOOPBACK = 3'h2;
   localparam logic [1:0] FMODE0 = 2'h0;
   localparam int REQ_FLAG_BIT = 3;
   localparam int TXERR_BIT = 4;
   localparam int TXDONE_BIT = 7;
   localparam int REMOTE_REQ_BIT = 6;
   localparam int FULL_FLAG_BIT = 7;
   localparam int ACCEPT_HIGH_BIT = 6;
   localparam int ACCEPT_LOW_BIT = 5;
   localparam int DBEN_BIT = 2;
   localparam logic [7:0] SIDL_MASK = 8'hEB;
   localparam logic [7:0] LEN_MASK = 8'h4F;
   localparam logic [3:0] LEN_MAX = 4'h8;
   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h80;
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] TEC_RESET = 8'h00;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   // error counting
   localparam logic [8:0] TEC_ERR_STEP = 9'h008;
   localparam logic [7:0] TEC_FULL = 8'hFF;
   localparam logic [6:0] RECOVER_LAST = 7'h7F;
   // host command port
   localparam logic [3:0] H_CMD = 4'h0;
   localparam logic [3:0] H_ID_HI = 4'h1;
   localparam logic [3:0] H_ID_LO = 4'h2;
   localparam logic [3:0] H_LEN = 4'h3;
   localparam logic [3:0] H_D0 = 4'h4;
   localparam logic [3:0] H_STATUS = 4'hC;
   localparam logic [3:0] LOAD_SIDL = 4'h8;
   localparam logic [3:0] LOAD_SIDH = 4'h9;
   localparam logic [3:0] LOAD_LEN = 4'hA;
endpackage

//--- design/cmb_link_if.sv
`timescale 1ns/1ps
interface cmb_link_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic wr;
   logic rd;
   logic [7:0] rdata;
   modport host (output addr, output wdata, output wr, output rd, input rdata);
   modport device (input addr, input wdata, input wr, input rd, output rdata);
endinterface

//--- design/cmb_device.sv
`timescale 1ns/1ps
// How it works
// RL1: remote bit sent equals length register bit 6
// RL2: length code 0-8 gives bytes; above reserved
// RL3: length register bits 7,5,4 read zero
// RL4: read-only error counter; overflow enters bus-off
// RL5: 128 runs of 11 recessive clear counter
// RL6: software selects normal or loopback before sending
// RL7: software loads buffer, then writes request 08h
// RL8: software polls request flag until it clears
// RL9: window in control low nibble; 1000 maps buffer
// RL10: mapped window redirects receive addresses to transmit
// RL11: standard id split high byte, low top
// RL12: receive full flag; software clears; resets zero
// RL13: mode 0 two-bit accept mode selection
// RL14: modes 1,2 bit 6 selects accept mode
// RL15: received remote flag bit 3 or 5
// RL16: modes 1,2 bits 4,3 upper filter index
// RL17: request flag clears after successful send
// RL18: full flag set on load; blocks new loads
// RL19: mode 0 double buffer overflows to buffer 1
// RL20: five-bit filter index names accepting filter
// RL21: reserved length codes treated as eight bytes
// RL22: counter follows protocol fault confinement steps
module cmb_device
   import cmb_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   cmb_link_if.device bus,
   // protocol engine on the same clock, no synchronisers
   input wire logic tx_sent_ok,
   input wire logic tx_failed,
   input wire logic rx_frame_valid,
   input wire logic rx_frame_ext,
   input wire logic rx_frame_rtr,
   input wire logic rx_frame_errored,
   input wire logic rx_filter_match,
   input wire logic [4:0] rx_filter_index,
   input wire logic rx_filter_ext_sel,
   input wire logic recessive_run_seen,
   output logic tx_frame_req,
   output logic [7:0] tx_id_high,
   output logic [7:0] tx_id_low,
   output logic [15:0] tx_ext_id,
   output logic tx_remote,
   output logic [3:0] tx_len,
   output logic [1:0] tx_pri,
   output logic [63:0] tx_data,
   output logic bus_off,
   output logic rx_to_buffer1,
   output logic rx_dropped
);
   logic [7:0] ctrl, next_ctrl, cfg, next_cfg, tec, next_tec, rdata, next_rdata;
   logic [7:0] sidh, next_sidh, sidl, next_sidl, eidh, next_eidh, eidl, next_eidl;
   logic [7:0] dlc, next_dlc;
   logic [7:0] buf_data [8];
   logic [7:0] next_buf_data [8];
   logic tx_req, next_tx_req, tx_err, next_tx_err, tx_done, next_tx_done;
   logic [1:0] pri, next_pri;
   logic rx_full, next_rx_full, rx_m1, next_rx_m1, rx_m0, next_rx_m0;
   logic rx_dben, next_rx_dben, rx_rtr, next_rx_rtr;
   logic [4:0] rx_hit, next_rx_hit;
   logic next_bus_off, next_req_q, next_to_b1, next_dropped;
   logic [6:0] rec_cnt, next_rec_cnt;
   logic [3:0] next_len;
   logic [7:0] eff;
   logic mode0, accept, frame_ok, wr_ok;
   logic [8:0] tec_sum;

   always_comb begin
      eff = bus.addr;
      if (ctrl[3:0] == WIN_TX0 && bus.addr >= A_RX0_CON && bus.addr <= A_RX0_LAST) begin
         eff = bus.addr + A_WIN_SHIFT; // RL10 RL9
      end
   end

   assign mode0 = (cfg[7:6] == FMODE0);
   assign frame_ok = !rx_frame_errored;

   always_comb begin
      accept = 1'b0;
      if (mode0) begin
         case ({rx_m1, rx_m0}) // RL13
            2'b11: accept = 1'b1;
            2'b10: accept = frame_ok && rx_filter_match && rx_frame_ext;
            2'b01: accept = frame_ok && rx_filter_match && !rx_frame_ext;
            default: accept = frame_ok && rx_filter_match && (rx_frame_ext == rx_filter_ext_sel);
         endcase
      end else begin
         accept = rx_m1 || (frame_ok && rx_filter_match); // RL14
      end
   end

   always_comb begin
      next_ctrl = ctrl;
      next_cfg = cfg;
      next_tec = tec;
      next_sidh = sidh;
      next_sidl = sidl;
      next_eidh = eidh;
      next_eidl = eidl;
      next_dlc = dlc;
      for (int i = 0; i < 8; i++) begin
         next_buf_data[i] = buf_data[i];
      end
      next_tx_req = tx_req;
      next_tx_err = tx_err;
      next_tx_done = tx_done;
      next_pri = pri;
      next_rx_full = rx_full;
      next_rx_m1 = rx_m1;
      next_rx_m0 = rx_m0;
      next_rx_dben = rx_dben;
      next_rx_rtr = rx_rtr;
      next_rx_hit = rx_hit;
      next_bus_off = bus_off;
      next_rec_cnt = rec_cnt;
      next_to_b1 = 1'b0;
      next_dropped = 1'b0;
      next_rdata = BYTE_RESET;
      tec_sum = {1'b0, tec} + TEC_ERR_STEP;
      wr_ok = bus.wr && !tx_req;

      // transmit outcome from the engine
      if (tx_req && tx_sent_ok) begin
         next_tx_req = 1'b0; // RL17
      end

      // software writes
      if (bus.wr) begin
         if (eff == A_CAN_CONTROL) begin
            next_ctrl = bus.wdata; // RL9
         end else if (eff == A_CAN_CONFIG) begin
            next_cfg = bus.wdata;
         end else if (eff == A_RX0_CON) begin
            if (!bus.wdata[FULL_FLAG_BIT]) begin
               next_rx_full = 1'b0; // RL12
            end
            next_rx_m1 = bus.wdata[ACCEPT_HIGH_BIT];
            if (mode0) begin
               next_rx_m0 = bus.wdata[ACCEPT_LOW_BIT];
               next_rx_dben = bus.wdata[DBEN_BIT];
            end
         end else if (eff == A_TX0_CON) begin
            next_pri = bus.wdata[1:0];
            if (!bus.wdata[TXDONE_BIT]) begin
               next_tx_done = 1'b0;
            end
            if (bus.wdata[REQ_FLAG_BIT] && !tx_req) begin
               next_tx_err = 1'b0;
            end
            // clearing a pending request aborts it
            next_tx_req = bus.wdata[REQ_FLAG_BIT];
         end
      end
      if (wr_ok) begin
         // buffer stays read-only while a request is pending
         if (eff == A_TX0_SIDH) begin
            next_sidh = bus.wdata;
         end else if (eff == A_TX0_SIDL) begin
            next_sidl = bus.wdata & SIDL_MASK;
         end else if (eff == A_TX0_EIDH) begin
            next_eidh = bus.wdata;
         end else if (eff == A_TX0_EIDL) begin
            next_eidl = bus.wdata;
         end else if (eff == A_TX0_LEN) begin
            next_dlc = bus.wdata & LEN_MASK; // RL3
         end
         for (int i = 0; i < 8; i++) begin
            if (eff == A_TX0_D0 + 8'(i)) begin
               next_buf_data[i] = bus.wdata;
            end
         end
      end

      // hardware sets win over software clears
      if (tx_req && tx_sent_ok) begin
         next_tx_done = 1'b1;
      end
      if (tx_req && tx_failed) begin
         next_tx_err = 1'b1;
      end
      if (rx_frame_valid && accept) begin
         if (!next_rx_full) begin
            next_rx_full = 1'b1; // RL18
            next_rx_rtr = rx_frame_rtr; // RL15
            next_rx_hit = rx_filter_index; // RL20
         end else if (mode0 && rx_dben) begin
            next_to_b1 = 1'b1; // RL19
         end else begin
            next_dropped = 1'b1; // RL18
         end
      end

      // fault confinement
      if (bus_off) begin
         if (recessive_run_seen) begin
            if (rec_cnt == RECOVER_LAST) begin
               next_tec = TEC_RESET; // RL5
               next_bus_off = 1'b0;
               next_rec_cnt = 7'h00;
            end else begin
               next_rec_cnt = rec_cnt + 7'h01;
            end
         end
      end else if (tx_req && tx_failed) begin
         if (tec_sum[8]) begin
            next_bus_off = 1'b1; // RL4
            next_tec = TEC_FULL;
         end else begin
            next_tec = tec_sum[7:0]; // RL22
         end
      end else if (tx_req && tx_sent_ok && tec != TEC_RESET) begin
         next_tec = tec - 8'h01; // RL22
      end

      // read data, one cycle after the strobe
      if (bus.rd) begin
         if (eff == A_CAN_CONTROL) begin
            next_rdata = ctrl;
         end else if (eff == A_CAN_CONFIG) begin
            next_rdata = cfg;
         end else if (eff == A_TX_ERR) begin
            next_rdata = tec; // RL4
         end else if (eff == A_RX0_CON && mode0) begin
            next_rdata = {rx_full, rx_m1, rx_m0, 1'b0, rx_rtr, rx_dben, rx_dben, rx_hit[0]}; // RL15
         end else if (eff == A_RX0_CON) begin
            next_rdata = {rx_full, rx_m1, rx_rtr, rx_hit}; // RL16 RL15 RL14
         end else if (eff == A_TX0_CON) begin
            next_rdata = {tx_done, 2'b00, tx_err, tx_req, 1'b0, pri};
         end else if (eff == A_TX0_SIDH) begin
            next_rdata = sidh;
         end else if (eff == A_TX0_SIDL) begin
            next_rdata = sidl;
         end else if (eff == A_TX0_EIDH) begin
            next_rdata = eidh;
         end else if (eff == A_TX0_EIDL) begin
            next_rdata = eidl;
         end else if (eff == A_TX0_LEN) begin
            next_rdata = dlc; // RL3
         end else begin
            for (int i = 0; i < 8; i++) begin
               if (eff == A_TX0_D0 + 8'(i)) begin
                  next_rdata = buf_data[i];
               end
            end
         end
      end

      // engine request only in normal or loopback operation
      next_req_q = next_tx_req && !next_bus_off &&
                   (next_ctrl[7:5] == OPM_NORMAL || next_ctrl[7:5] == OPM_LOOPBACK); // RL6
      next_len = (next_dlc[3:0] > LEN_MAX) ? LEN_MAX : next_dlc[3:0]; // RL2 RL21
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= CTRL_RESET;
         cfg <= CONFIG_RESET;
         tec <= TEC_RESET; // RL4
         rdata <= BYTE_RESET;
         sidh <= BYTE_RESET;
         sidl <= BYTE_RESET;
         eidh <= BYTE_RESET;
         eidl <= BYTE_RESET;
         dlc <= BYTE_RESET;
         for (int i = 0; i < 8; i++) begin
            buf_data[i] <= BYTE_RESET;
         end
         tx_req <= 1'b0;
         tx_err <= 1'b0;
         tx_done <= 1'b0;
         pri <= 2'b00;
         rx_full <= 1'b0; // RL12
         rx_m1 <= 1'b0;
         rx_m0 <= 1'b0;
         rx_dben <= 1'b0;
         rx_rtr <= 1'b0;
         rx_hit <= 5'h00;
         bus_off <= 1'b0;
         rec_cnt <= 7'h00;
         tx_frame_req <= 1'b0;
         tx_len <= 4'h0;
         rx_to_buffer1 <= 1'b0;
         rx_dropped <= 1'b0;
      end else begin
         ctrl <= next_ctrl;
         cfg <= next_cfg;
         tec <= next_tec;
         rdata <= next_rdata;
         sidh <= next_sidh;
         sidl <= next_sidl;
         eidh <= next_eidh;
         eidl <= next_eidl;
         dlc <= next_dlc;
         for (int i = 0; i < 8; i++) begin
            buf_data[i] <= next_buf_data[i];
         end
         tx_req <= next_tx_req;
         tx_err <= next_tx_err;
         tx_done <= next_tx_done;
         pri <= next_pri;
         rx_full <= next_rx_full;
         rx_m1 <= next_rx_m1;
         rx_m0 <= next_rx_m0;
         rx_dben <= next_rx_dben;
         rx_rtr <= next_rx_rtr;
         rx_hit <= next_rx_hit;
         bus_off <= next_bus_off;
         rec_cnt <= next_rec_cnt;
         tx_frame_req <= next_req_q;
         tx_len <= next_len;
         rx_to_buffer1 <= next_to_b1;
         rx_dropped <= next_dropped;
      end
   end

   assign bus.rdata = rdata;
   assign tx_id_high = sidh;
   assign tx_id_low = sidl;
   assign tx_ext_id = {eidh, eidl};
   assign tx_remote = dlc[REMOTE_REQ_BIT]; // RL1
   assign tx_pri = pri;

   for (genvar g = 0; g < 8; g++) begin : g_pack
      assign tx_data[8*g +: 8] = buf_data[g];
   end
endmodule

//--- design/cmb_host.sv
`timescale 1ns/1ps
module cmb_host
   import cmb_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   cmb_link_if.host bus,
   input wire logic [3:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata
);
   typedef enum logic [9:0] {
      S_IDLE = 10'h001,
      S_RD_CTRL = 10'h002,
      S_WT_CTRL = 10'h004,
      S_CAP_CTRL = 10'h008,
      S_LOAD = 10'h010,
      S_REQ = 10'h020,
      S_POLL = 10'h040,
      S_POLL_WT = 10'h080,
      S_POLL_CAP = 10'h100,
      S_UNUSED = 10'h200
   } cmb_state_type;

   cmb_state_type state, next_state;
   logic [7:0] id_hi, next_id_hi, len_rtr, next_len_rtr, b_addr, next_b_addr;
   logic [7:0] b_wdata, next_b_wdata, next_sw_rdata, keep;
   logic [2:0] id_lo, next_id_lo;
   logic [7:0] data [8];
   logic [7:0] next_data [8];
   logic [3:0] idx, next_idx;
   logic b_wr, next_b_wr, b_rd, next_b_rd, busy, next_busy, done, next_done;

   always_comb begin
      next_state = state;
      next_id_hi = id_hi;
      next_id_lo = id_lo;
      next_len_rtr = len_rtr;
      for (int i = 0; i < 8; i++) begin
         next_data[i] = data[i];
      end
      next_idx = idx;
      next_busy = busy;
      next_done = done;
      next_b_addr = b_addr;
      next_b_wdata = b_wdata;
      next_b_wr = 1'b0;
      next_b_rd = 1'b0;
      next_sw_rdata = BYTE_RESET;
      keep = bus.rdata & WIN_KEEP_MASK;
      if (keep[7:5] != OPM_NORMAL && keep[7:5] != OPM_LOOPBACK) begin
         keep[7:5] = OPM_NORMAL; // RL6
      end

      if (sw_wr && !busy) begin
         if (sw_addr == H_ID_HI) begin
            next_id_hi = sw_wdata;
         end else if (sw_addr == H_ID_LO) begin
            next_id_lo = sw_wdata[2:0];
         end else if (sw_addr == H_LEN) begin
            next_len_rtr = sw_wdata;
         end else if (sw_addr >= H_D0 && sw_addr < H_STATUS) begin
            next_data[3'(sw_addr - H_D0)] = sw_wdata;
         end
      end
      if (sw_rd) begin
         if (sw_addr == H_STATUS) begin
            next_sw_rdata = {6'h00, done, busy};
         end else if (sw_addr == H_ID_HI) begin
            next_sw_rdata = id_hi;
         end else if (sw_addr == H_LEN) begin
            next_sw_rdata = len_rtr;
         end
      end

      case (state)
         S_IDLE: begin
            if (sw_wr && sw_addr == H_CMD && sw_wdata[0] && !busy) begin
               next_busy = 1'b1;
               next_done = 1'b0;
               next_state = S_RD_CTRL;
            end
         end
         S_RD_CTRL: begin
            next_b_rd = 1'b1;
            next_b_addr = A_CAN_CONTROL;
            next_state = S_WT_CTRL;
         end
         S_WT_CTRL: begin
            next_state = S_CAP_CTRL;
         end
         S_CAP_CTRL: begin
            next_b_wr = 1'b1;
            next_b_addr = A_CAN_CONTROL;
            next_b_wdata = keep | {4'h0, WIN_TX0}; // RL9
            next_idx = 4'h0;
            next_state = S_LOAD;
         end
         S_LOAD: begin
            next_b_wr = 1'b1; // RL7
            next_idx = idx + 4'h1;
            if (idx == LOAD_SIDL) begin
               next_b_addr = A_RX0_SIDL;
               next_b_wdata = {id_lo, 5'h00}; // RL11
            end else if (idx == LOAD_SIDH) begin
               next_b_addr = A_RX0_SIDH;
               next_b_wdata = id_hi; // RL11
            end else if (idx == LOAD_LEN) begin
               next_b_addr = A_RX0_LEN;
               next_b_wdata = len_rtr & LEN_MASK;
               next_state = S_REQ;
            end else begin
               next_b_addr = A_RX0_D0 + {4'h0, idx}; // RL10
               next_b_wdata = data[idx[2:0]];
            end
         end
         S_REQ: begin
            next_b_wr = 1'b1;
            next_b_addr = A_RX0_CON;
            next_b_wdata = TX_REQ_WORD; // RL7
            next_state = S_POLL;
         end
         S_POLL: begin
            next_b_rd = 1'b1;
            next_b_addr = A_RX0_CON;
            next_state = S_POLL_WT;
         end
         S_POLL_WT: begin
            next_state = S_POLL_CAP;
         end
         S_POLL_CAP: begin
            if (bus.rdata[REQ_FLAG_BIT]) begin
               next_state = S_POLL; // RL8
            end else begin
               next_busy = 1'b0;
               next_done = 1'b1;
               next_state = S_IDLE;
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= S_IDLE;
         id_hi <= BYTE_RESET;
         id_lo <= 3'h0;
         len_rtr <= BYTE_RESET;
         for (int i = 0; i < 8; i++) begin
            data[i] <= BYTE_RESET;
         end
         idx <= 4'h0;
         busy <= 1'b0;
         done <= 1'b0;
         b_addr <= BYTE_RESET;
         b_wdata <= BYTE_RESET;
         b_wr <= 1'b0;
         b_rd <= 1'b0;
         sw_rdata <= BYTE_RESET;
      end else begin
         state <= next_state;
         id_hi <= next_id_hi;
         id_lo <= next_id_lo;
         len_rtr <= next_len_rtr;
         for (int i = 0; i < 8; i++) begin
            data[i] <= next_data[i];
         end
         idx <= next_idx;
         busy <= next_busy;
         done <= next_done;
         b_addr <= next_b_addr;
         b_wdata <= next_b_wdata;
         b_wr <= next_b_wr;
         b_rd <= next_b_rd;
         sw_rdata <= next_sw_rdata;
      end
   end

   assign bus.addr = b_addr;
   assign bus.wdata = b_wdata;
   assign bus.wr = b_wr;
   assign bus.rd = b_rd;
endmodule

//--- bench/cmb_link_monitor.sv
`timescale 1ns/1ps
module cmb_link_monitor
   import cmb_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata
);
   logic [3:0] buffer_window_select;
   logic [3:0] next_win;
   logic tx0con_hit;
   // transmit control is reached directly or through the window
   assign tx0con_hit = addr == A_TX0_CON || (addr == A_RX0_CON && buffer_window_select == WIN_TX0);
   always_comb begin
      next_win = buffer_window_select;
      if (wr && addr == A_CAN_CONTROL) begin
         next_win = wdata[3:0];
      end
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         buffer_window_select <= 4'h0;
      end else begin
         buffer_window_select <= next_win;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   rdata_idle_a: assert property (!rd |=> rdata == 8'h00)
      else $error("read data outside read answer");
   strobe_excl_a: assert property (!(wr && rd))
      else $error("write and read strobes together");
   win_read_a: assert property (rd && addr == A_CAN_CONTROL |=> rdata[3:0] == buffer_window_select)
      else $error("window field read back wrong");
   win_write_a: assert property (wr && addr == A_CAN_CONTROL |-> wdata[3:0] == WIN_TX0)
      else $error("window not set to transmit buffer");
   req_word_a: assert property (wr && tx0con_hit |-> wdata == TX_REQ_WORD)
      else $error("request word wrong");
   sidl_std_a: assert property (wr && (addr == A_TX0_SIDL ||
      (addr == A_RX0_SIDL && buffer_window_select == WIN_TX0)) |-> wdata[4:0] == 5'h00)
      else $error("standard id low byte wrong");
   poll_gap_a: assert property (rd && tx0con_hit |=> !rd ##1 !rd)
      else $error("poll spacing wrong");
   txcon_layout_a: assert property (rd && tx0con_hit |=> (rdata & 8'h64) == 8'h00)
      else $error("window read not transmit control");
   cover property (wr && addr == A_CAN_CONTROL);
   cover property (wr && tx0con_hit);
   cover property (rd && tx0con_hit ##1 !rdata[REQ_FLAG_BIT]);
endmodule

//--- bench/can_msg_buffer_regs_tb_top.sv
`timescale 1ns/1ps
module can_msg_buffer_regs_tb_top import cmb_pkg::*; ;
   // each row: length register, id high, id low, expected payload length
   typedef struct packed {logic [7:0] len; logic [7:0] idh; logic [2:0] idl;
      logic [3:0] xlen;} cmb_row_type;
   localparam cmb_row_type ROWS [5] = '{'{8'h00, 8'h24, 3'h3, 4'h0},
      '{8'h48, 8'hFF, 3'h7, 4'h8}, '{8'h09, 8'h00, 3'h0, 4'h8},
      '{8'h4F, 8'h81, 3'h5, 4'h8}, '{8'h05, 8'h5A, 3'h2, 4'h5}};
   // each entry: frame extended, frame errored, drop expected
   localparam logic [2:0] RXT [5] = '{3'b010, 3'b100, 3'b000, 3'b010, 3'b001};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] sw_addr = 4'h0;
   logic [7:0] sw_wdata = 8'h00;
   logic sw_wr = 1'b0, sw_rd = 1'b0;
   logic [7:0] sw_rdata;
   logic tx_sent_ok = 1'b0, tx_failed = 1'b0, recessive_run_seen = 1'b0;
   logic rx_frame_valid = 1'b0, rx_frame_ext = 1'b0, rx_frame_rtr = 1'b0;
   logic rx_frame_errored = 1'b0, rx_filter_match = 1'b0, rx_filter_ext_sel = 1'b0;
   logic [4:0] rx_filter_index = 5'h00;
   logic tx_frame_req, tx_remote, bus_off, rx_to_buffer1, rx_dropped;
   logic [7:0] tx_id_high, tx_id_low;
   logic [15:0] tx_ext_id;
   logic [3:0] tx_len;
   logic [1:0] tx_pri;
   logic [63:0] tx_data;
   int fails = 0;
   int samples_checked = 0;
   cmb_link_if cmb_link_if_i ();
   cmb_host cmb_host_i (.clk(clk), .rst(rst), .bus(cmb_link_if_i.host), .sw_addr(sw_addr),
      .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
   cmb_device cmb_device_i (.clk(clk), .rst(rst), .bus(cmb_link_if_i.device),
      .tx_sent_ok(tx_sent_ok), .tx_failed(tx_failed), .rx_frame_valid(rx_frame_valid),
      .rx_frame_ext(rx_frame_ext), .rx_frame_rtr(rx_frame_rtr),
      .rx_frame_errored(rx_frame_errored), .rx_filter_match(rx_filter_match),
      .rx_filter_index(rx_filter_index), .rx_filter_ext_sel(rx_filter_ext_sel),
      .recessive_run_seen(recessive_run_seen), .tx_frame_req(tx_frame_req),
      .tx_id_high(tx_id_high), .tx_id_low(tx_id_low), .tx_ext_id(tx_ext_id),
      .tx_remote(tx_remote), .tx_len(tx_len), .tx_pri(tx_pri), .tx_data(tx_data),
      .bus_off(bus_off), .rx_to_buffer1(rx_to_buffer1), .rx_dropped(rx_dropped));
   cmb_link_monitor cmb_link_monitor_i (.clk(clk), .rst(rst), .addr(cmb_link_if_i.addr),
      .wdata(cmb_link_if_i.wdata), .wr(cmb_link_if_i.wr), .rd(cmb_link_if_i.rd),
      .rdata(cmb_link_if_i.rdata));
   initial begin
      forever #12.5 clk = ~clk;
   end
   task automatic check(input string what, input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic conclude();
      if (fails == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask
   task automatic sw_status(output logic [7:0] s);
      @(posedge clk);
      sw_addr <= H_STATUS;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1;
      s = sw_rdata;
   endtask
   // one-cycle pulse on sent_ok, failed, recessive run
   task automatic pulse(input logic [2:0] sel);
      @(posedge clk);
      {tx_sent_ok, tx_failed, recessive_run_seen} <= sel;
      @(posedge clk);
      {tx_sent_ok, tx_failed, recessive_run_seen} <= 3'b000;
      #1;
   endtask
   task automatic wait_req(input logic v);
      int n;
      // step off the edge that may launch the request
      #1;
      for (n = 0; n < 300 && tx_frame_req !== v; n++) begin
         @(posedge clk);
         #1;
      end
      if (n == 300) begin
         fails++;
         conclude();
      end
   endtask
   task automatic wait_done();
      logic [7:0] s;
      int n;
      for (n = 0; n < 50; n++) begin
         sw_status(s);
         if (s[1] === 1'b1) break;
      end
      check("done", s[1:0], 2'b10);
      if (n == 50) conclude();
   endtask
   task automatic load_and_start(input cmb_row_type r);
      sw_write(H_ID_HI, r.idh);
      sw_write(H_ID_LO, {5'h00, r.idl});
      sw_write(H_LEN, r.len);
      for (int i = 0; i < 8; i++) sw_write(4'(H_D0 + i), r.idh ^ 8'(i));
      sw_write(H_CMD, 8'h01);
      wait_req(1'b1);
   endtask
   task automatic rx_offer(input logic ext, input logic err, input logic drop);
      @(posedge clk);
      rx_frame_valid <= 1'b1;
      rx_frame_ext <= ext;
      rx_frame_errored <= err;
      rx_filter_match <= 1'b1;
      rx_frame_rtr <= ext;
      rx_filter_index <= 5'h01;
      @(posedge clk);
      rx_frame_valid <= 1'b0;
      #1;
      check("rx_dropped", rx_dropped, drop);
      check("rx_to_buffer1", rx_to_buffer1, 1'b0);
   endtask
   initial begin
      cmb_row_type r;
      logic [7:0] st;
      logic [63:0] d;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      check("tx_frame_req", tx_frame_req, 1'b0);
      check("bus_off", bus_off, 1'b0);
      sw_status(st);
      check("status", st, 8'h00);
      foreach (ROWS[k]) begin
         r = ROWS[k];
         load_and_start(r);
         for (int i = 0; i < 8; i++) d[8*i +: 8] = r.idh ^ 8'(i);
         check("tx_len", tx_len, r.xlen);
         check("tx_remote", tx_remote, r.len[6]);
         check("tx_id_high", tx_id_high, r.idh);
         check("tx_id_low", tx_id_low, {r.idl, 5'h00});
         check("tx_pri", tx_pri, 2'h0);
         check("tx_data", tx_data, d);
         check("tx_ext_id", tx_ext_id, 16'h0000);
         pulse(3'b100);
         check("tx_frame_req", tx_frame_req, 1'b0);
         wait_done();
      end
      load_and_start(ROWS[1]);
      repeat (31) pulse(3'b010);
      check("bus_off", bus_off, 1'b0);
      pulse(3'b010);
      check("bus_off", bus_off, 1'b1);
      wait_req(1'b0);
      repeat (127) pulse(3'b001);
      check("bus_off", bus_off, 1'b1);
      pulse(3'b001);
      check("bus_off", bus_off, 1'b0);
      wait_req(1'b1);
      pulse(3'b100);
      wait_done();
      foreach (RXT[k]) rx_offer(RXT[k][2], RXT[k][1], RXT[k][0]);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      sw_status(st);
      check("status", st, 8'h00);
      rx_offer(1'b0, 1'b0, 1'b0);
      conclude();
   end
endmodule
